// ==== sar_search.sv ====
`default_nettype none

// ==========================================================================
// Shared constants
package sar_pkg;
    localparam int          RES_BITS       = 12;
    localparam int          CONV_CYC       = 18;
    localparam int          SAMPLE_CYC     = CONV_CYC - RES_BITS;
    localparam int          CLK_HZ         = 20_000_000;
    localparam int          PWR_WAIT_NS    = 10_000;
    localparam int          PWR_WAIT_CYC   = (PWR_WAIT_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int          CONV_DIV       = 2;
    localparam int          CONV_HZ_MAX    = 18_000_000;
    localparam int          CONV_HZ_MIN    = 1_000_000;
    localparam logic [11:0] RESULT_RST     = 12'h000;
    typedef enum logic [1:0] {WAKE, IDLE, SAMPLE, CONVERT} conv_state_e;
endpackage : sar_pkg

// ==========================================================================
// Binary search engine, one decision per converter clock tick
module sar_search import sar_pkg::*; #(
    parameter int BITS = RES_BITS
) (
    input  wire logic            clk,
    input  wire logic            resetn,
    input  wire logic            go,
    input  wire logic            tick,
    input  wire logic            comp_in,
    output logic [BITS-1:0]      dac_code,
    output logic                 finish
);
    logic [BITS-1:0]         code_ff;
    logic [$clog2(BITS)-1:0] idx_ff;
    logic                    busy_ff;

    initial begin
        if (BITS < 2) $error("BITS must be at least 2");
    end

    assign dac_code = code_ff;
    assign finish   = busy_ff && tick && (idx_ff == '0);

    // MSB first: trial bit kept when the comparator input is high (input at or above the DAC level)
    always_ff @(posedge clk) begin
        if (!resetn) begin
            code_ff <= '0;
            idx_ff  <= '0;
            busy_ff <= 1'b0;
        end else if (go) begin
            code_ff <= {1'b1, {(BITS-1){1'b0}}};
            idx_ff  <= ($clog2(BITS))'(BITS - 1);
            busy_ff <= 1'b1;
        end else if (busy_ff && tick) begin
            if (!comp_in) begin
                code_ff[idx_ff] <= 1'b0;
            end
            if (idx_ff == '0) begin
                busy_ff <= 1'b0;
            end else begin
                code_ff[idx_ff - 1'b1] <= 1'b1;
                idx_ff                 <= idx_ff - 1'b1;
            end
        end
    end
endmodule : sar_search

`default_nettype wire

// ==== sar_adc_conversion_control.sv ====
`default_nettype none

module sar_adc_conversion_control import sar_pkg::*; #(
    parameter int BITS     = RES_BITS,
    parameter int DIV      = CONV_DIV,
    parameter int WAIT_CYC = PWR_WAIT_CYC
) (
    input  wire logic            clk,
    input  wire logic            resetn,
    input  wire logic            wake,
    input  wire logic            start_bit,
    input  wire logic            trig_in,
    input  wire logic            single_sel,
    input  wire logic            result_rd,
    input  wire logic            status_clr,
    input  wire logic            comp_in,
    output logic [BITS-1:0]      dac_code,
    output logic [BITS-1:0]      result,
    output logic                 done,
    output logic                 status,
    output logic                 ready,
    output logic                 sampling
);
    // ======================================================================
    // Declarations
    conv_state_e               state_ff;
    logic [$clog2(WAIT_CYC+1)-1:0] wait_ff;
    logic [$clog2(DIV+1)-1:0]  div_ff;
    logic [4:0]                samp_ff;
    logic                      trig_ff;
    logic                      pend_ff;
    logic                      run_ff;
    logic [BITS-1:0]           result_ff;
    logic                      done_ff;
    logic                      status_ff;
    logic                      tick;
    logic                      trig_rise;
    logic                      req;
    logic                      go;
    logic                      finish;

    initial begin
        if (BITS != RES_BITS) $error("Result width must match the search length");
        if (DIV < 1 || CLK_HZ / DIV > CONV_HZ_MAX) $error("Converter clock above 18 MHz");
        if (CLK_HZ / DIV < CONV_HZ_MIN) $error("Converter clock below 1 MHz");
        if (WAIT_CYC < 8) $error("WAIT_CYC must be at least 8");
    end

    // ======================================================================
    // Converter clock: the system clock divided, so that DIV sets the rate
    // the analog side sees; 20 MHz / 2 keeps it inside 1..18 MHz
    always_ff @(posedge clk) begin
        if (!resetn || go) begin
            div_ff <= '0;
        end else if (div_ff == ($clog2(DIV+1))'(DIV - 1)) begin
            div_ff <= '0;
        end else begin
            div_ff <= div_ff + 1'b1;
        end
    end
    assign tick = (div_ff == ($clog2(DIV+1))'(DIV - 1));

    // ======================================================================
    // Start requests
    always_ff @(posedge clk) begin
        if (!resetn) begin
            trig_ff <= 1'b0;
        end else begin
            trig_ff <= trig_in;
        end
    end
    // Trigger counts on its rising edge only, so a long pulse is one request
    assign trig_rise = trig_in && !trig_ff;
    assign req       = start_bit || trig_rise || pend_ff;
    // Single select is honoured on the edge it is first seen, before run_ff clears
    assign go        = (state_ff == IDLE) && (req || (run_ff && !single_sel));

    // A trigger that lands mid-conversion is kept, not dropped
    always_ff @(posedge clk) begin
        if (!resetn || wake) begin
            pend_ff <= 1'b0;
        end else if ((state_ff == SAMPLE || state_ff == CONVERT) && (start_bit || trig_rise)) begin
            pend_ff <= 1'b1;
        end else if (go) begin
            pend_ff <= 1'b0;
        end
    end

    // Continuous run: armed by the first start, dropped by single select
    always_ff @(posedge clk) begin
        if (!resetn || wake || single_sel) begin
            run_ff <= 1'b0;
        end else if (go) begin
            run_ff <= 1'b1;
        end
    end

    // ======================================================================
    // Sequencer
    always_ff @(posedge clk) begin
        if (!resetn || wake) begin
            state_ff <= WAKE;
            wait_ff  <= '0;
            samp_ff  <= '0;
        end else begin
            case (state_ff)
                WAKE: begin
                    wait_ff <= wait_ff + 1'b1;
                    if (wait_ff == ($clog2(WAIT_CYC+1))'(WAIT_CYC - 1)) begin
                        state_ff <= IDLE;
                    end
                end
                IDLE: begin
                    samp_ff <= '0;
                    if (go) begin
                        state_ff <= SAMPLE;
                    end
                end
                SAMPLE: begin
                    if (tick) begin
                        samp_ff <= samp_ff + 1'b1;
                        if (samp_ff == 5'(SAMPLE_CYC - 1)) begin
                            state_ff <= CONVERT;
                        end
                    end
                end
                CONVERT: begin
                    if (finish) begin
                        state_ff <= IDLE;
                    end
                end
                default: begin
                    state_ff <= WAKE;
                end
            endcase
        end
    end

    sar_search #(
        .BITS (BITS)
    ) u_search (
        .clk      (clk),
        .resetn   (resetn),
        .go       ((state_ff == SAMPLE) && tick && (samp_ff == 5'(SAMPLE_CYC - 1))),
        .tick     (tick),
        .comp_in  (comp_in),
        .dac_code (dac_code),
        .finish   (finish)
    );

    // ======================================================================
    // Result and completion flags; a new result wins over a same-cycle read
    always_ff @(posedge clk) begin
        if (!resetn) begin
            result_ff <= RESULT_RST;
        end else if (finish) begin
            result_ff <= {dac_code[BITS-1:1], comp_in};
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            done_ff <= 1'b0;
        end else if (finish) begin
            done_ff <= 1'b1;
        end else if (result_rd) begin
            done_ff <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            status_ff <= 1'b0;
        end else if (finish) begin
            status_ff <= 1'b1;
        end else if (status_clr) begin
            status_ff <= 1'b0;
        end
    end

    assign result   = result_ff;
    assign done     = done_ff;
    assign status   = status_ff;
    assign ready    = (state_ff != WAKE);
    assign sampling = (state_ff == SAMPLE);

    // ======================================================================
    // Checks
    logic [5:0] conv_cnt_ff;
    always_ff @(posedge clk) begin
        if (!resetn || go) begin
            conv_cnt_ff <= '0;
        end else if (state_ff != IDLE && state_ff != WAKE && tick) begin
            conv_cnt_ff <= conv_cnt_ff + 1'b1;
        end
    end

    property p_no_start_in_wait;
        @(posedge clk) disable iff (!resetn)
        state_ff == WAKE |-> !go && !pend_ff;
    endproperty
    a_no_start_in_wait: assert property (p_no_start_in_wait)
        else $error("Conversion started during power-up wait");

    property p_wait_length;
        @(posedge clk) disable iff (!resetn)
        $rose(state_ff == WAKE) |-> (state_ff == WAKE) [*8];
    endproperty
    a_wait_length: assert property (p_wait_length)
        else $error("Power-up wait ended early");

    property p_eighteen_ticks;
        @(posedge clk) disable iff (!resetn || wake)
        finish |-> conv_cnt_ff == 6'(CONV_CYC - 1);
    endproperty
    a_eighteen_ticks: assert property (p_eighteen_ticks)
        else $error("Conversion did not take eighteen converter clocks");

    property p_done_set;
        @(posedge clk) disable iff (!resetn)
        finish |=> done && status;
    endproperty
    a_done_set: assert property (p_done_set)
        else $error("Completion did not raise done and status");

    property p_done_holds;
        @(posedge clk) disable iff (!resetn)
        done && !result_rd && !finish |=> done;
    endproperty
    a_done_holds: assert property (p_done_holds)
        else $error("Done dropped without a read");

    property p_read_clears;
        @(posedge clk) disable iff (!resetn)
        result_rd && !finish |=> !done;
    endproperty
    a_read_clears: assert property (p_read_clears)
        else $error("Read did not clear done");

    property p_result_stable;
        @(posedge clk) disable iff (!resetn)
        !$past(finish) |-> $stable(result);
    endproperty
    a_result_stable: assert property (p_result_stable)
        else $error("Result changed without a completion");

    property p_msb_first;
        @(posedge clk) disable iff (!resetn || wake)
        $rose(state_ff == CONVERT) |-> dac_code[BITS-1] && dac_code[BITS-2:0] == '0;
    endproperty
    a_msb_first: assert property (p_msb_first)
        else $error("Search did not start at the MSB");

    property p_continuous;
        @(posedge clk) disable iff (!resetn || wake)
        finish && run_ff && !single_sel ##1 !single_sel |=> state_ff == SAMPLE;
    endproperty
    a_continuous: assert property (p_continuous)
        else $error("Continuous mode did not restart at once");

    property p_single_once;
        @(posedge clk) disable iff (!resetn || wake)
        state_ff == IDLE && single_sel && !pend_ff && !start_bit && !trig_rise |-> !go;
    endproperty
    a_single_once: assert property (p_single_once)
        else $error("Single mode converted without a request");

    c_single: cover property (@(posedge clk) disable iff (!resetn)
        single_sel && trig_rise && state_ff == IDLE ##[1:60] finish);
    c_cont: cover property (@(posedge clk) disable iff (!resetn)
        finish && run_ff ##[1:60] finish);
    c_pend: cover property (@(posedge clk) disable iff (!resetn)
        pend_ff && go);
    c_read: cover property (@(posedge clk) disable iff (!resetn)
        done ##1 result_rd ##1 !done);
endmodule : sar_adc_conversion_control

`default_nettype wire

// ==== sar_reader_model.sv ====
`default_nettype none

// ==========================================================================
// CPU or DMA reader with comparator front end
module sar_reader_model import sar_pkg::*; (
    input  wire logic        clk,
    input  wire logic        resetn,
    input  wire logic        done,
    input  wire logic [11:0] result,
    input  wire logic [11:0] dac_code,
    input  wire logic [11:0] level,
    input  wire logic        rd_en,
    input  wire logic        slow,
    output logic             result_rd,
    output logic             comp_in,
    output logic [11:0]      got,
    output int               reads
);
    logic [4:0] wait_ff;

    // Ideal comparator, so the search must land exactly on the level
    assign comp_in = (level >= dac_code);

    // Done serves as the transfer request; a slow reader leaves it standing
    always_ff @(posedge clk) begin
        if (!resetn) begin
            result_rd <= 1'b0;
            wait_ff   <= 5'h00;
            got       <= 12'h000;
            reads     <= 0;
        end else begin
            result_rd <= 1'b0;
            if (done && rd_en && !result_rd) begin
                if (wait_ff == (slow ? 5'h14 : 5'h00)) begin
                    result_rd <= 1'b1;
                    got       <= result;
                    reads     <= reads + 1;
                    wait_ff   <= 5'h00;
                end else begin
                    wait_ff <= wait_ff + 5'h01;
                end
            end
        end
    end
endmodule : sar_reader_model

`default_nettype wire

// ==== test_sar_adc_conversion_control.sv ====
`default_nettype none

module test_sar_adc_conversion_control;
    timeunit 1ns;
    timeprecision 1ps;
    import sar_pkg::*;

    localparam int WAITC = 8;
    logic        clk = 1'b0;
    logic        resetn = 1'b0;
    logic        wake = 1'b0;
    logic        start_bit = 1'b0;
    logic        trig_in = 1'b0;
    logic        single_sel = 1'b1;
    logic        status_clr = 1'b0;
    logic        rd_en = 1'b0;
    logic        slow = 1'b0;
    logic [11:0] level = 12'h000;
    logic        result_rd, comp_in, done, status, ready, sampling;
    logic [11:0] dac_code, result, got;
    int          reads;
    int          failures = 0;
    int          checks = 0;

    always #25 clk = ~clk;

    sar_adc_conversion_control #(.WAIT_CYC(WAITC)) uut (
        .clk(clk), .resetn(resetn), .wake(wake), .start_bit(start_bit),
        .trig_in(trig_in), .single_sel(single_sel), .result_rd(result_rd),
        .status_clr(status_clr), .comp_in(comp_in), .dac_code(dac_code),
        .result(result), .done(done), .status(status), .ready(ready),
        .sampling(sampling));

    sar_reader_model reader (
        .clk(clk), .resetn(resetn), .done(done), .result(result),
        .dac_code(dac_code), .level(level), .rd_en(rd_en), .slow(slow),
        .result_rd(result_rd), .comp_in(comp_in), .got(got), .reads(reads));

    task automatic finish_test;
        if (failures == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : finish_test

    task automatic check(string name, logic [11:0] exp, logic [11:0] seen);
        checks++;
        if (seen !== exp) begin
            $display("unexpected %s expected %h seen %h", name, exp, seen);
            failures++;
        end
    endtask : check

    // Bounded wait for done; returns the cycles spent
    task automatic wait_done(input int lim, output int n);
        n = 0;
        while (done !== 1'b1 && n < lim) begin
            @(negedge clk);
            n++;
        end
        if (n >= lim) begin
            check("done wait", 12'h001, 12'h000);
            finish_test();
        end
    endtask : wait_done

    task automatic pulse(ref logic sig);
        sig = 1'b1;
        @(negedge clk);
        sig = 1'b0;
    endtask : pulse

    // Start pulses before the power-up wait has run out are dropped
    task automatic t_early_start;
        check("reset result", 12'h000, result);
        check("reset flags", 12'h000, {9'h000, done, status, ready});
        pulse(start_bit);
        repeat (WAITC + 4) @(negedge clk);
        check("early done", 12'h000, {11'h000, done});
        check("ready", 12'h001, {11'h000, ready});
    endtask : t_early_start

    // One software start per level: timing, value, standing done, status clear
    task automatic t_single;
        logic [11:0] lv [5] = '{12'h000, 12'hfff, 12'h800, 12'h7ff, 12'ha53};
        int n;
        foreach (lv[i]) begin
            level = lv[i];
            pulse(start_bit);
            check("sampling", 12'h001, {11'h000, sampling});
            wait_done(60, n);
            check("conversion cycles", 12'h001, {11'h000, n >= 34 && n <= 42});
            check("result", lv[i], result);
            check("dac code", lv[i], dac_code);
            check("status", 12'h001, {11'h000, status});
            repeat (6) @(negedge clk);
            check("done held", 12'h001, {11'h000, done});
            pulse(status_clr);
            check("status cleared", 12'h000, {11'h000, status});
            rd_en = 1'b1;
            repeat (4) @(negedge clk);
            rd_en = 1'b0;
            check("done after read", 12'h000, {11'h000, done});
        end
    endtask : t_single

    // A held trigger gives exactly one conversion; slow reader
    task automatic t_trigger;
        int n;
        level = 12'h3c6;
        slow = 1'b1;
        rd_en = 1'b1;
        trig_in = 1'b1;
        wait_done(60, n);
        check("trig result", 12'h3c6, result);
        repeat (100) @(negedge clk);
        check("trig reads", 12'h001, reads[11:0] - 12'h005);
        check("trig done", 12'h000, {11'h000, done});
        trig_in = 1'b0;
        rd_en = 1'b0;
        slow = 1'b0;
    endtask : t_trigger

    // Continuous run drained by the reader, then stopped by single select
    task automatic t_continuous;
        int base;
        level = 12'h5a5;
        single_sel = 1'b0;
        rd_en = 1'b1;
        base = reads;
        pulse(start_bit);
        repeat (200) @(negedge clk);
        check("stream reads", 12'h001, {11'h000, reads - base >= 4});
        check("stream value", 12'h5a5, got);
        single_sel = 1'b1;
        repeat (60) @(negedge clk);
        base = reads;
        repeat (80) @(negedge clk);
        check("stopped", 12'h000, 12'(reads - base));
        rd_en = 1'b0;
    endtask : t_continuous

    // Wake restarts the wait and drops starts made inside it
    task automatic t_wake;
        int base;
        pulse(wake);
        check("wake ready", 12'h000, {11'h000, ready});
        pulse(start_bit);
        repeat (WAITC + 4) @(negedge clk);
        check("wake done", 12'h000, {11'h000, done});
        check("wake ready back", 12'h001, {11'h000, ready});
        // A start during a conversion is kept and served once the first ends
        rd_en = 1'b1;
        base = reads;
        pulse(start_bit);
        repeat (4) @(negedge clk);
        pulse(start_bit);
        repeat (90) @(negedge clk);
        check("pending start", 12'h002, 12'(reads - base));
        rd_en = 1'b0;
    endtask : t_wake

    initial begin
        repeat (3) @(negedge clk);
        resetn = 1'b1;
        t_early_start();
        t_single();
        t_trigger();
        t_continuous();
        t_wake();
        finish_test();
    end
endmodule : test_sar_adc_conversion_control

`default_nettype wire
